// [core/iorg_pkg.sv]
// shared constants, types and helpers of the io register gearbox
package iorg_pkg;
    localparam int          APB_AW        = 12;
    localparam logic [11:0] ADDR_CTRL     = 12'h000;
    localparam logic [11:0] ADDR_DELAY    = 12'h004;
    localparam logic [11:0] ADDR_ALIGN    = 12'h008;
    localparam logic [11:0] ADDR_STATUS   = 12'h00c;
    localparam logic [11:0] ADDR_WORD     = 12'h010;
    localparam int          CTRL_W        = 10;
    localparam int          TAP_W         = 5;
    localparam int          TAPS          = 32;
    localparam int          FIXED_DLY_CYC = 2;
    localparam int          GEAR_W        = 8;
    localparam int          SH_W          = 16;
    localparam logic [3:0]  RATIO_BY7     = 4'h7;
    localparam logic [3:0]  RATIO_BY8     = 4'h8;
    localparam logic [3:0]  RATIO_BY4     = 4'h4;
    localparam logic [4:0]  TAP_RST       = 5'h00;
    localparam logic [2:0]  SEL_RST       = 3'h0;

    typedef enum logic [1:0] {IN_BYPASS, IN_SDR, IN_DDR} iorg_in_mode_e;
    typedef enum logic [1:0] {GEAR_BY7, GEAR_BY8, GEAR_DUAL4} iorg_gear_e;

    typedef struct packed {
        logic          dyn_dly_en;
        logic          fix_dly_en;
        logic          comp_en;
        logic          ce;
        iorg_gear_e    gear;
        logic          out_latch;
        logic          out_ddr;
        iorg_in_mode_e in_mode;
    } iorg_ctrl_s;

    localparam iorg_ctrl_s CTRL_RST = '{dyn_dly_en: 1'b0, fix_dly_en: 1'b0,
        comp_en: 1'b0, ce: 1'b1, gear: GEAR_BY8, out_latch: 1'b0,
        out_ddr: 1'b0, in_mode: IN_SDR};

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } iorg_apb_req_s;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } iorg_apb_rsp_s;

    // bits per word and lane for each gearing
    function automatic logic [3:0] gear_ratio(iorg_gear_e g);
        case (g)
            GEAR_BY7:   gear_ratio = RATIO_BY7;
            GEAR_DUAL4: gear_ratio = RATIO_BY4;
            default:    gear_ratio = RATIO_BY8;
        endcase
    endfunction
endpackage

// [core/iorg_deser.sv]
// input gearbox: serial capture, word alignment, word hand-off
`timescale 1ns/1ns
module iorg_deser (
    input  logic                ref_clk,
    input  logic                rst,
    input  logic                ce,
    input  iorg_pkg::iorg_gear_e gear,
    input  logic                lane_a_in,
    input  logic                lane_c_in,
    input  logic                word_align_request,
    output logic [7:0]          word,
    output logic                word_valid,
    output logic [2:0]          align_select
);
    logic [15:0] sh_a_reg, sh_a_next, sh_c_reg, sh_c_next;
    logic [2:0]  cnt_reg, cnt_next, sel_reg, sel_next;
    logic [7:0]  algn_reg, algn_next, word_reg, word_next;
    logic        upd_reg, upd_next, vld_reg, vld_next;
    logic        pend_reg, pend_next, last;
    logic [3:0]  r;
    logic [7:0]  wa, wc;

    // window of r bits, earliest bit lands in bit 0
    function automatic logic [7:0] pick(logic [15:0] sh, logic [3:0] n,
                                        logic [2:0] s);
        logic [7:0] w;
        int         b;
        w = 8'h00;
        b = 16 - int'(n) - int'(s);
        for (int k = 0; k < 8; k++) begin
            if (k < int'(n)) begin
                w[k] = sh[b + k];
            end
        end
        return w;
    endfunction

    always_comb begin
        r         = iorg_pkg::gear_ratio(gear);
        last      = (cnt_reg == 3'(r - 4'h1));
        wa        = pick(sh_a_reg, r, sel_reg);
        wc        = pick(sh_c_reg, r, sel_reg);
        sh_a_next = sh_a_reg;
        sh_c_next = sh_c_reg;
        cnt_next  = cnt_reg;
        sel_next  = sel_reg;
        algn_next = algn_reg;
        word_next = word_reg;
        upd_next  = 1'b0;
        vld_next  = 1'b0;
        pend_next = pend_reg | word_align_request;
        if (ce) begin
            sh_a_next = {lane_a_in, sh_a_reg[15:1]};
            sh_c_next = {lane_c_in, sh_c_reg[15:1]};
            cnt_next  = last ? 3'h0 : cnt_reg + 3'h1;
            upd_next  = last;
            vld_next  = upd_reg;
            if (last) begin
                if (gear == iorg_pkg::GEAR_DUAL4) begin
                    algn_next = {wa[3:0], wc[3:0]};
                end else begin
                    algn_next = wa;
                end
                if (pend_reg) begin
                    sel_next  = (sel_reg == 3'(r - 4'h1)) ? 3'h0
                                                          : sel_reg + 3'h1;
                    pend_next = word_align_request;
                end
            end
            if (upd_reg) begin
                word_next = algn_reg;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sh_a_reg <= 16'h0000;
            sh_c_reg <= 16'h0000;
            cnt_reg  <= 3'h0;
            sel_reg  <= iorg_pkg::SEL_RST;
            algn_reg <= 8'h00;
            word_reg <= 8'h00;
            upd_reg  <= 1'b0;
            vld_reg  <= 1'b0;
            pend_reg <= 1'b0;
        end else begin
            sh_a_reg <= sh_a_next;
            sh_c_reg <= sh_c_next;
            cnt_reg  <= cnt_next;
            sel_reg  <= sel_next;
            algn_reg <= algn_next;
            word_reg <= word_next;
            upd_reg  <= upd_next;
            vld_reg  <= vld_next;
            pend_reg <= pend_next;
        end
    end

    assign word         = word_reg;
    assign word_valid   = vld_reg;
    assign align_select = sel_reg;
endmodule

// [core/iorg_ser.sv]
// output gearbox: word capture, hand-over, serial shift-out
`timescale 1ns/1ns
module iorg_ser (
    input  logic                ref_clk,
    input  logic                rst,
    input  logic                ce,
    input  iorg_pkg::iorg_gear_e gear,
    input  logic [7:0]          word_in,
    output logic                word_taken,
    output logic                lane_a_out,
    output logic                lane_c_out
);
    logic [7:0] cap_reg, cap_next, hold_reg, hold_next, sh_reg, sh_next;
    logic [2:0] cnt_reg, cnt_next;
    logic       tk_reg, tk_next, a_reg, a_next, c_reg, c_next, last;
    logic [3:0] r;

    always_comb begin
        r         = iorg_pkg::gear_ratio(gear);
        last      = (cnt_reg == 3'(r - 4'h1));
        cap_next  = cap_reg;
        hold_next = hold_reg;
        sh_next   = sh_reg;
        cnt_next  = cnt_reg;
        tk_next   = 1'b0;
        a_next    = a_reg;
        c_next    = c_reg;
        if (ce) begin
            cnt_next = last ? 3'h0 : cnt_reg + 3'h1;
            if (cnt_reg == 3'h0) begin
                cap_next = word_in;
                tk_next  = 1'b1;
                if (gear == iorg_pkg::GEAR_BY7) begin
                    cap_next[7] = 1'b0;
                end
            end
            if (cnt_reg == 3'h1) begin
                hold_next = cap_reg;
            end
            sh_next = last ? hold_reg : {1'b0, sh_reg[7:1]};
            a_next  = sh_next[0];
            c_next  = (gear == iorg_pkg::GEAR_DUAL4) ? sh_next[4] : 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cap_reg  <= 8'h00;
            hold_reg <= 8'h00;
            sh_reg   <= 8'h00;
            cnt_reg  <= 3'h0;
            tk_reg   <= 1'b0;
            a_reg    <= 1'b0;
            c_reg    <= 1'b0;
        end else begin
            cap_reg  <= cap_next;
            hold_reg <= hold_next;
            sh_reg   <= sh_next;
            cnt_reg  <= cnt_next;
            tk_reg   <= tk_next;
            a_reg    <= a_next;
            c_reg    <= c_next;
        end
    end

    assign word_taken = tk_reg;
    assign lane_a_out = a_reg;
    assign lane_c_out = c_reg;
endmodule

// [core/iorg_top.sv]
// io cell group top: pin logic, gearboxes and register slave
//
// The APB slave port and the address map were left to the implementer.
`timescale 1ns/1ns
module iorg_top (
    input  logic                    ref_clk,
    input  logic                    rst,
    input  iorg_pkg::iorg_apb_req_s apb_req,
    output iorg_pkg::iorg_apb_rsp_s apb_rsp,
    input  logic                    pad_in,
    input  logic                    gear_lane_a_in,
    input  logic                    gear_lane_c_in,
    input  logic                    core_out_first_bit,
    input  logic                    core_out_second_bit,
    input  logic                    core_tristate_ctl,
    input  logic                    word_align_request,
    input  logic [7:0]              ser_word,
    output logic                    bypass_input,
    output logic                    bypass_clock_input,
    output logic                    rise_capture,
    output logic                    fall_capture,
    output logic                    pad_out,
    output logic                    pad_out_comp,
    output logic                    pad_tristate_out,
    output logic [7:0]              deser_word,
    output logic                    deser_word_valid,
    output logic [2:0]              align_select,
    output logic                    ser_word_taken,
    output logic                    ser_lane_a_out,
    output logic                    ser_lane_c_out
);
    // pin synchronisers
    logic [1:0]  pad_sync_reg, pad_sync_next;
    logic [1:0]  ga_sync_reg, ga_sync_next;
    logic [1:0]  gc_sync_reg, gc_sync_next;
    logic        pad_s, ga_s, gc_s;

    // registers reached over the bus
    iorg_pkg::iorg_ctrl_s ctrl_reg, ctrl_next;
    logic [4:0]  tap_reg, tap_next;
    logic        swal_reg, swal_next;
    logic [31:0] rdata_reg, rdata_next;
    logic        err_reg, err_next;
    logic        acc_setup, acc_write, hit;

    // delay lines
    logic [31:0] dly_reg, dly_next;
    logic [31:0] dla_reg, dla_next;
    logic        din, gin;

    // slow clock model and cell registers
    logic        ph_reg, ph_next;
    logic        sclk_rise, sclk_fall, sclk_high;
    logic        rc_reg, rc_next, fc_reg, fc_next;
    logic        q0_reg, q0_next, q1a_reg, q1a_next, q1b_reg, q1b_next;
    logic        tq_reg, tq_next, po_reg, po_next, pc_reg, pc_next;

    // gearbox side
    logic        align_req;
    logic [7:0]  dw;
    logic        dv;
    logic [2:0]  dsel;

    // true where an address maps a register
    function automatic logic addr_hit(logic [11:0] a);
        addr_hit = (a == iorg_pkg::ADDR_CTRL) || (a == iorg_pkg::ADDR_DELAY)
                || (a == iorg_pkg::ADDR_ALIGN)
                || (a == iorg_pkg::ADDR_STATUS)
                || (a == iorg_pkg::ADDR_WORD);
    endfunction

    // tap selection from a delay line
    function automatic logic dly_pick(logic [31:0] line, logic raw,
                                      logic fix_en, logic dyn_en,
                                      logic [4:0] tap);
        if (dyn_en) begin
            dly_pick = line[tap];
        end else if (fix_en) begin
            dly_pick = line[iorg_pkg::FIXED_DLY_CYC - 1];
        end else begin
            dly_pick = raw;
        end
    endfunction

    // pins pass two flops before use
    always_comb begin
        pad_sync_next = {pad_sync_reg[0], pad_in};
        ga_sync_next  = {ga_sync_reg[0], gear_lane_a_in};
        gc_sync_next  = {gc_sync_reg[0], gear_lane_c_in};
        pad_s         = pad_sync_reg[1];
        ga_s          = ga_sync_reg[1];
        gc_s          = gc_sync_reg[1];
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pad_sync_reg <= 2'h0;
            ga_sync_reg  <= 2'h0;
            gc_sync_reg  <= 2'h0;
        end else begin
            pad_sync_reg <= pad_sync_next;
            ga_sync_reg  <= ga_sync_next;
            gc_sync_reg  <= gc_sync_next;
        end
    end

    // register slave, zero wait states
    always_comb begin
        acc_setup  = apb_req.psel && !apb_req.penable;
        acc_write  = apb_req.psel && apb_req.penable && apb_req.pwrite;
        hit        = addr_hit(apb_req.paddr);
        ctrl_next  = ctrl_reg;
        tap_next   = tap_reg;
        swal_next  = 1'b0;
        rdata_next = rdata_reg;
        err_next   = err_reg;
        if (acc_setup) begin
            err_next   = !hit;
            rdata_next = 32'h0000_0000;
            case (apb_req.paddr)
                iorg_pkg::ADDR_CTRL: begin
                    rdata_next[iorg_pkg::CTRL_W-1:0] = ctrl_reg;
                end
                iorg_pkg::ADDR_DELAY: begin
                    rdata_next[iorg_pkg::TAP_W-1:0] = tap_reg;
                end
                iorg_pkg::ADDR_ALIGN: begin
                    rdata_next[2:0] = dsel;
                end
                iorg_pkg::ADDR_STATUS: begin
                    rdata_next[5:0] = {tq_reg, po_reg, fc_reg, rc_reg,
                                       din, pad_s};
                end
                iorg_pkg::ADDR_WORD: begin
                    rdata_next[7:0] = dw;
                end
                default: begin
                    rdata_next = 32'h0000_0000;
                end
            endcase
        end
        if (acc_write && hit) begin
            case (apb_req.paddr)
                iorg_pkg::ADDR_CTRL: begin
                    ctrl_next = iorg_pkg::iorg_ctrl_s'(
                        apb_req.pwdata[iorg_pkg::CTRL_W-1:0]);
                end
                iorg_pkg::ADDR_DELAY: begin
                    tap_next = apb_req.pwdata[iorg_pkg::TAP_W-1:0];
                end
                iorg_pkg::ADDR_ALIGN: begin
                    swal_next = apb_req.pwdata[0];
                end
                default: begin
                    swal_next = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ctrl_reg  <= iorg_pkg::CTRL_RST;
            tap_reg   <= iorg_pkg::TAP_RST;
            swal_reg  <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            err_reg   <= 1'b0;
        end else begin
            ctrl_reg  <= ctrl_next;
            tap_reg   <= tap_next;
            swal_reg  <= swal_next;
            rdata_reg <= rdata_next;
            err_reg   <= err_next;
        end
    end

    always_comb begin
        apb_rsp.prdata  = rdata_reg;
        apb_rsp.pready  = apb_req.psel && apb_req.penable;
        apb_rsp.pslverr = apb_req.psel && apb_req.penable && err_reg;
    end

    // fixed and dynamic input delay
    always_comb begin
        dly_next = {dly_reg[30:0], pad_s};
        dla_next = {dla_reg[30:0], ga_s};
        din      = dly_pick(dly_reg, pad_s, ctrl_reg.fix_dly_en,
                            ctrl_reg.dyn_dly_en, tap_reg);
        gin      = dly_pick(dla_reg, ga_s, ctrl_reg.fix_dly_en,
                            ctrl_reg.dyn_dly_en, tap_reg);
    end

    // slow clock phase and cell capture
    always_comb begin
        ph_next   = ~ph_reg;
        sclk_rise = ~ph_reg;
        sclk_fall = ph_reg;
        sclk_high = ph_reg;
        rc_next   = rc_reg;
        fc_next   = fc_reg;
        q0_next   = q0_reg;
        q1a_next  = q1a_reg;
        q1b_next  = q1b_reg;
        tq_next   = tq_reg;
        if (ctrl_reg.ce) begin
            case (ctrl_reg.in_mode)
                iorg_pkg::IN_SDR: begin
                    if (sclk_rise) begin
                        fc_next = din;
                    end
                end
                iorg_pkg::IN_DDR: begin
                    if (sclk_rise) begin
                        rc_next = din;
                    end
                    if (sclk_fall) begin
                        fc_next = din;
                    end
                end
                default: begin
                    fc_next = fc_reg;
                end
            endcase
            if (ctrl_reg.out_ddr) begin
                if (sclk_rise) begin
                    q0_next  = core_out_first_bit;
                    q1a_next = core_out_second_bit;
                end
                if (sclk_fall) begin
                    q1b_next = q1a_reg;
                end
            end else if (ctrl_reg.out_latch) begin
                if (sclk_high) begin
                    q0_next = core_out_first_bit;
                end
            end else if (sclk_rise) begin
                q0_next = core_out_first_bit;
            end
            if (sclk_rise) begin
                tq_next = core_tristate_ctl;
            end
        end
        if (ctrl_reg.out_ddr) begin
            po_next = ph_next ? q0_next : q1b_next;
        end else begin
            po_next = q0_next;
        end
        pc_next = ctrl_reg.comp_en ? ~po_next : 1'b0;
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            dly_reg <= 32'h0000_0000;
            dla_reg <= 32'h0000_0000;
            ph_reg  <= 1'b0;
            rc_reg  <= 1'b0;
            fc_reg  <= 1'b0;
            q0_reg  <= 1'b0;
            q1a_reg <= 1'b0;
            q1b_reg <= 1'b0;
            tq_reg  <= 1'b0;
            po_reg  <= 1'b0;
            pc_reg  <= 1'b0;
        end else begin
            dly_reg <= dly_next;
            dla_reg <= dla_next;
            ph_reg  <= ph_next;
            rc_reg  <= rc_next;
            fc_reg  <= fc_next;
            q0_reg  <= q0_next;
            q1a_reg <= q1a_next;
            q1b_reg <= q1b_next;
            tq_reg  <= tq_next;
            po_reg  <= po_next;
            pc_reg  <= pc_next;
        end
    end

    // bypass leaves the capture and delay-line stages out but keeps the two-flop pin synchroniser
    assign bypass_input       = pad_s;
    assign bypass_clock_input = pad_s;
    assign rise_capture       = rc_reg;
    assign fall_capture       = fc_reg;
    assign pad_out            = po_reg;
    assign pad_out_comp       = pc_reg;
    assign pad_tristate_out   = tq_reg;

    // core and software alignment requests merge
    assign align_req = word_align_request | swal_reg;

    iorg_deser u_deser (
        .ref_clk            (ref_clk),
        .rst                (rst),
        .ce                 (ctrl_reg.ce),
        .gear               (ctrl_reg.gear),
        .lane_a_in          (gin),
        .lane_c_in          (gc_s),
        .word_align_request (align_req),
        .word               (dw),
        .word_valid         (dv),
        .align_select       (dsel)
    );

    iorg_ser u_ser (
        .ref_clk    (ref_clk),
        .rst        (rst),
        .ce         (ctrl_reg.ce),
        .gear       (ctrl_reg.gear),
        .word_in    (ser_word),
        .word_taken (ser_word_taken),
        .lane_a_out (ser_lane_a_out),
        .lane_c_out (ser_lane_c_out)
    );

    assign deser_word       = dw;
    assign deser_word_valid = dv;
    assign align_select     = dsel;
endmodule

// [dv/iorg_partner.sv]
// partner model: serial word source and serial output capture
`timescale 1ns/1ns
module iorg_partner (
    input  logic       ref_clk,
    input  logic [7:0] tx_word,
    input  logic [3:0] ratio,
    input  logic       ser_lane_a_out,
    input  logic       ser_lane_c_out,
    output logic       gear_lane_a_in,
    output logic       gear_lane_c_in,
    output logic [7:0] rx_hist,
    output logic [7:0] rx_hist_c
);
    logic [3:0] bit_idx;
    initial {bit_idx, gear_lane_a_in, gear_lane_c_in, rx_hist, rx_hist_c} = '0;
    always @(posedge ref_clk) begin
        bit_idx        <= (bit_idx + 4'h1 >= ratio) ? 4'h0 : bit_idx + 4'h1;
        gear_lane_a_in <= tx_word[bit_idx[2:0]];
        gear_lane_c_in <= tx_word[bit_idx[2:0]];
        rx_hist        <= {ser_lane_a_out, rx_hist[7:1]};
        rx_hist_c      <= {ser_lane_c_out, rx_hist_c[7:1]};
    end
endmodule

// [dv/iorg_top_assertions.sv]
// port checker of the io register gearbox top
`timescale 1ns/1ns
module iorg_top_assertions (
    input logic       ref_clk,
    input logic       rst,
    input logic       pad_in,
    input logic       bypass_input,
    input logic       bypass_clock_input,
    input logic       pad_out,
    input logic       pad_out_comp,
    input logic       pad_tristate_out,
    input logic       deser_word_valid,
    input logic       ser_word_taken,
    input logic [2:0] align_select
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    a_bypass_pair: assert property (bypass_clock_input == bypass_input)
        else $error("bypass pair differs");
    a_bypass_sync: assert property (!$past(rst) && !$past(rst, 2)
        |-> bypass_input == $past(pad_in, 2)) else $error("bypass lag");
    a_reset_clear: assert property (disable iff (1'h0) rst |=>
        !pad_out && !pad_tristate_out && !deser_word_valid && !bypass_input
        && !ser_word_taken && align_select == 3'h0) else $error("no clear");
    a_comp_inverse: assert property (pad_out_comp |-> !pad_out)
        else $error("complement wrong");
    a_tri_hold: assert property ($changed(pad_tristate_out)
        |=> $stable(pad_tristate_out)) else $error("tristate moved twice");
    a_deser_pulse: assert property (deser_word_valid
        |=> !deser_word_valid) else $error("word valid too long");
    a_ser_pulse: assert property ($rose(ser_word_taken)
        |=> $fell(ser_word_taken)) else $error("word taken too long");
    a_align_step: assert property ($changed(align_select) |->
        align_select == $past(align_select) + 3'h1 || align_select == 3'h0)
        else $error("select jumped");
    c_word: cover property (deser_word_valid);
    c_taken: cover property (ser_word_taken);
    c_align: cover property ($changed(align_select));
endmodule

bind iorg_top iorg_top_assertions u_iorg_top_assertions (.ref_clk, .rst,
    .pad_in, .bypass_input, .bypass_clock_input, .pad_out, .pad_out_comp,
    .pad_tristate_out, .deser_word_valid, .ser_word_taken, .align_select);

// [dv/iorg_top_bench.sv]
// self-checking bench of the io register gearbox top
`timescale 1ns/1ns
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin \
    error_cnt++; $display("BAD %s exp %0h got %0h", n, e, s); end end
module iorg_top_bench;
    iorg_pkg::iorg_apb_req_s apb_req = '0;
    iorg_pkg::iorg_apb_rsp_s apb_rsp;
    logic        ref_clk = 1'h0, rst = 1'h1, pad_in = 1'h0, prev_out, rd_err;
    logic        core_out_first_bit = 1'h0, core_out_second_bit = 1'h0;
    logic        core_tristate_ctl = 1'h0, word_align_request = 1'h0;
    logic        gear_lane_a_in, gear_lane_c_in, bypass_input, rise_capture;
    logic        bypass_clock_input, fall_capture, pad_out, pad_out_comp;
    logic        pad_tristate_out, deser_word_valid, ser_word_taken;
    logic        ser_lane_a_out, ser_lane_c_out;
    logic [7:0]  ser_word = 8'h1c, tx_word = 8'ha5, deser_word, rx_hist;
    logic [7:0]  rx_hist_c;
    logic [3:0]  ratio = 4'h8;
    logic [2:0]  align_select, sel_old;
    logic [31:0] rd_data;
    int          error_cnt = 0, samples_checked = 0, cycles = 0, gap;

    always #2 ref_clk = ~ref_clk;

    iorg_top u_iorg_top (.ref_clk, .rst, .apb_req, .apb_rsp, .pad_in,
        .gear_lane_a_in, .gear_lane_c_in, .core_out_first_bit,
        .core_out_second_bit, .core_tristate_ctl, .word_align_request,
        .ser_word, .bypass_input, .bypass_clock_input, .rise_capture,
        .fall_capture, .pad_out, .pad_out_comp, .pad_tristate_out,
        .deser_word, .deser_word_valid, .align_select, .ser_word_taken,
        .ser_lane_a_out, .ser_lane_c_out);
    iorg_partner u_iorg_partner (.ref_clk, .tx_word, .ratio, .ser_lane_a_out,
        .gear_lane_a_in, .gear_lane_c_in, .rx_hist, .ser_lane_c_out,
        .rx_hist_c);

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 3000) begin
            error_cnt++;
            wrap_up;
        end
    end

    task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
        @(posedge ref_clk) apb_req <= '{1'h1, 1'h0, w, a, d};
        @(posedge ref_clk) apb_req.penable <= 1'h1;
        do @(posedge ref_clk); while (apb_rsp.pready !== 1'h1);
        rd_data = apb_rsp.prdata;
        rd_err  = apb_rsp.pslverr;
        apb_req <= '0;
    endtask

    task automatic look(int n);
        repeat (n) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask

    function automatic logic is_rot(logic [7:0] w, logic [7:0] x);
        is_rot = 1'h0;
        for (int i = 0; i < 8; i++)
            if (w == 8'((x >> i) | (x << (8 - i))))
                is_rot = 1'h1;
    endfunction

    task automatic t_regs;
        apb(1'h0, iorg_pkg::ADDR_CTRL, 32'h0);
        `CHK("ctrl", 32'h51, rd_data)
        apb(1'h0, 12'h100, 32'h0);
        `CHK("slverr", 1'h1, rd_err)
        `CHK("rdata", 32'h0, rd_data)
        apb(1'h1, iorg_pkg::ADDR_DELAY, 32'h5);
        apb(1'h0, iorg_pkg::ADDR_DELAY, 32'h0);
        `CHK("tap", 32'h5, rd_data)
        $display("test regs done");
    endtask

    task automatic t_pins;
        apb(1'h1, iorg_pkg::ADDR_CTRL, 32'hd1);
        @(posedge ref_clk) begin
            core_out_first_bit <= 1'h1;
            core_tristate_ctl  <= 1'h1;
            pad_in             <= 1'h1;
        end
        look(8);
        `CHK("pad_out", 1'h1, pad_out)
        `CHK("tri", 1'h1, pad_tristate_out)
        `CHK("comp", 1'h0, pad_out_comp)
        `CHK("bypass", 1'h1, bypass_input)
        `CHK("bypass_ck", 1'h1, bypass_clock_input)
        `CHK("sdr_in", 1'h1, fall_capture)
        apb(1'h1, iorg_pkg::ADDR_CTRL, 32'hd6);
        look(4);
        prev_out = pad_out;
        look(1);
        `CHK("ddr_alt", ~prev_out, pad_out)
        `CHK("ddr_in", 2'h3, {rise_capture, fall_capture})
        apb(1'h1, iorg_pkg::ADDR_CTRL, 32'h96);
        @(posedge ref_clk) pad_in <= 1'h0;
        look(8);
        `CHK("ce_hold", 1'h1, rise_capture)
        apb(1'h1, iorg_pkg::ADDR_CTRL, 32'hd9);
        @(posedge ref_clk) core_out_first_bit <= 1'h0;
        look(4);
        `CHK("latch_out", 1'h0, pad_out)
        `CHK("comp_on", 1'h1, pad_out_comp)
        $display("test pins done");
    endtask

    task automatic t_gear;
        for (int g = 0; g < 3; g++) begin
            apb(1'h1, iorg_pkg::ADDR_CTRL, 32'h41 | 32'(g << 4));
            ratio <= (g == 0) ? 4'h7 : (g == 1) ? 4'h8 : 4'h4;
            look(40);
            while (ser_word_taken !== 1'h1)
                @(negedge ref_clk);
            gap = 0;
            do begin
                @(negedge ref_clk);
                gap++;
            end while (ser_word_taken !== 1'h1);
            `CHK("taken_gap", ratio, gap[3:0])
            while (deser_word_valid !== 1'h1)
                @(negedge ref_clk);
            if (g == 0)
                `CHK("by7_msb", 1'h0, deser_word[7])
            else if (g == 2) begin
                `CHK("dual", deser_word[3:0], deser_word[7:4])
                `CHK("by4", 1'h1, is_rot({2{deser_word[7:4]}}, 8'h55))
                `CHK("ser4", 1'h1, is_rot(rx_hist, {2{ser_word[3:0]}}))
                `CHK("sc", 1'h1, is_rot(rx_hist_c, {2{ser_word[7:4]}}))
            end else begin
                `CHK("by8", 1'h1, is_rot(deser_word, tx_word))
                `CHK("ser8", 1'h1, is_rot(rx_hist, ser_word))
                `CHK("lane_c_idle", 1'h0, ser_lane_c_out)
                sel_old = align_select;
                @(posedge ref_clk) word_align_request <= 1'h1;
                @(posedge ref_clk) word_align_request <= 1'h0;
                look(24);
                `CHK("align", sel_old + 3'h1, align_select)
                apb(1'h0, iorg_pkg::ADDR_ALIGN, 32'h0);
                `CHK("align_reg", sel_old + 3'h1, rd_data[2:0])
            end
        end
        $display("test gear done");
    endtask

    initial begin
        repeat (4) @(posedge ref_clk);
        rst <= 1'h0;
        t_regs;
        t_pins;
        t_gear;
        wrap_up;
    end
endmodule
